// ---- design/mft_pkg.sv ----
/*
  shared constants and types of the timer control block.
  assumes an 8-bit register file port on the core clock.
*/
package mft_pkg;

  // ****************
  // register offsets
  // ****************
  localparam logic [7:0] CAPLOAD0_HIGH_OFS = 8'hf0;
  localparam logic [7:0] CAPLOAD0_LOW_OFS  = 8'hf1;
  localparam logic [7:0] CAPLOAD1_HIGH_OFS = 8'hf2;
  localparam logic [7:0] CAPLOAD1_LOW_OFS  = 8'hf3;
  localparam logic [7:0] COMPARE0_HIGH_OFS = 8'hf4;
  localparam logic [7:0] COMPARE0_LOW_OFS  = 8'hf5;
  localparam logic [7:0] COMPARE1_HIGH_OFS = 8'hf6;
  localparam logic [7:0] COMPARE1_LOW_OFS  = 8'hf7;
  localparam logic [7:0] CTRL_OFS          = 8'hf8;
  localparam logic [7:0] MODE_OFS          = 8'hf9;

  // ****************
  // reset values
  // ****************
  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam logic [7:0]  MODE_RESET    = 8'h00;
  localparam logic [15:0] COMPARE_RESET = 16'h0000;

  // ****************
  // counter_control fields
  // ****************
  localparam int CTRL_LOCAL_EN   = 7;
  localparam int CTRL_CLR_CAPT   = 6;
  localparam int CTRL_CLR_MATCH  = 5;
  localparam int CTRL_CLEAR      = 4;
  localparam int CTRL_SOFT_DIR   = 3;
  localparam int CTRL_DIR_STAT   = 2;
  localparam int CTRL_WRAP_STAT  = 1;
  localparam int CTRL_RUN_STAT   = 0;

  // ****************
  // operating_mode fields
  // ****************
  localparam int MODE_OUT_B_EN   = 7;
  localparam int MODE_OUT_A_EN   = 6;
  localparam int MODE_BIVALUE    = 5;
  localparam int MODE_REG1       = 4;
  localparam int MODE_REG0       = 3;
  localparam int MODE_CLK_CTRL   = 2;
  localparam int MODE_NO_RETRIG  = 1;
  localparam int MODE_ONE_SHOT   = 0;

  // counter limits
  localparam logic [15:0] COUNT_TOP    = 16'hffff;
  localparam logic [15:0] COUNT_BOTTOM = 16'h0000;

  // operating modes decoded from three mode bits
  typedef enum logic [2:0] {
    BILOAD, BICAPTURE, LOAD_MONITOR, LOAD_CAPTURE, CAPTURE_MONITOR, CAPTURE_CAPTURE
  } mft_mode_type;

  // one register file access
  typedef struct packed {
    logic       write;
    logic       read;
    logic [7:0] addr;
    logic [7:0] data;
  } mft_regreq_type;

  // trigger strobes from the input control logic
  typedef struct packed {
    logic capture0;
    logic capture1;
    logic load;
    logic gateOpen;
    logic dirFixed;
    logic dirUp;
  } mft_trig_type;

endpackage

// ---- design/mft_timer_control.sv ----
/*
  control and register part of the 16-bit multi-function timer:
  capture/load, compare, counter control, mode and end-of-block logic.
  assumes input control, prescaler preset, output action and dma mask
  registers live outside and talk to it on the same clock.
*/
`timescale 1ns/1ps

module mft_timer_control
  import mft_pkg::*;
(
  // clock and reset
  input  wire logic           mclk,
  input  wire logic           reset,
  // register file port
  input  wire mft_regreq_type regReq,
  output logic [7:0]          regReadData,
  // global enable and prescaler preset
  input  wire logic           globalCountEnable,
  input  wire logic [7:0]     prescalePreset,
  // triggers from input control, same clock
  input  wire mft_trig_type   trig,
  // raw timer input pins, for level status
  input  wire logic           timerInputA,
  input  wire logic           timerInputB,
  // levels from output action logic
  input  wire logic           actionLevelA,
  input  wire logic           actionLevelB,
  // timer output pins
  output logic                timerOutputA,
  output logic                timerOutputB,
  // end-of-block and dma side
  input  wire logic [1:0]     eobEvent,
  input  wire logic           eobWrite,
  input  wire logic [1:0]     eobWriteData,
  input  wire logic           swapEnable,
  input  wire logic [1:0]     dmaPending,
  input  wire logic           wrapIrqPending,
  output logic [1:0]          endOfBlockFlag,
  output logic [1:0]          dmaMaskClear,
  output logic [1:0]          eobIrqServe,
  // timer events
  output logic                wrapEvent,
  output logic                compare0Event,
  output logic                compare1Event,
  output logic                parallelMode,
  output logic [1:0]          inputLevel
);

  // ****************
  // state
  // ****************
  logic [15:0] capLoad0_reg;         // no reset, content undefined
  logic [15:0] capLoad1_reg;
  logic [15:0] compare0_reg;         // compare zero
  logic [15:0] compare1_reg;         // compare one
  logic [7:0]  ctrl_reg;             // writable control bits
  logic [7:0]  mode_reg;             // operating mode bits
  logic [15:0] count_reg;            // up/down counter
  logic [7:0]  prescale_reg;         // prescaler down counter
  logic        oneShotDone_reg;      // one shot ended
  logic        wrapSinceCap_reg;     // wrap since last capture 0
  logic        wrapStat_reg;         // read-only wrap status
  logic        biSelect_reg;         // biload/bicapture alternation
  logic [1:0]  eobPend_reg;          // end-of-block irq pending
  logic [1:0]  pinSync1_reg;         // first sync stage
  logic [1:0]  pinSync2_reg;         // second sync stage

  // ****************
  // decode
  // ****************
  wire wrEn   = regReq.write;
  wire wrCtrl = wrEn && (regReq.addr == CTRL_OFS);
  wire wrMode = wrEn && (regReq.addr == MODE_OFS);

  // register one bit ignored when bivalue
  mft_mode_type mode;
  assign mode = mode_reg[MODE_BIVALUE] ?
                (mode_reg[MODE_REG0] ? BICAPTURE : BILOAD) :
                (mode_reg[MODE_REG0] ?
                 (mode_reg[MODE_REG1] ? CAPTURE_CAPTURE : CAPTURE_MONITOR) :
                 (mode_reg[MODE_REG1] ? LOAD_CAPTURE : LOAD_MONITOR));

  wire reg0Capt = (mode == CAPTURE_MONITOR) || (mode == CAPTURE_CAPTURE);
  wire reg1Capt = (mode == LOAD_CAPTURE) || (mode == CAPTURE_CAPTURE);
  wire biCapt   = (mode == BICAPTURE);
  wire biLoad   = (mode == BILOAD);

  wire runEnable = ctrl_reg[CTRL_LOCAL_EN] && globalCountEnable &&
                   trig.gateOpen && !oneShotDone_reg;
  // prescaler at zero lets the counter step once
  wire tick      = runEnable && (prescale_reg == 8'h00);

  wire dirUp = trig.dirFixed ? trig.dirUp : ctrl_reg[CTRL_SOFT_DIR];

  wire atEnd   = dirUp ? (count_reg == COUNT_TOP) : (count_reg == COUNT_BOTTOM);
  wire wrapNow = tick && atEnd;

  wire match0 = (count_reg == compare0_reg);
  wire match1 = (count_reg == compare1_reg);

  // captures ignore the local enable
  // bivalue capture alternates between the two registers
  wire capt0 = trig.capture0 && (reg0Capt || (biCapt && !biSelect_reg));
  wire capt1 = (trig.capture1 && reg1Capt) ||
               (trig.capture0 && biCapt && biSelect_reg);
  wire loadTrig = trig.load && !reg0Capt && !biCapt;

  // retrigger restarts a finished one shot
  wire retrig = trig.load && !mode_reg[MODE_NO_RETRIG];

  wire clrCapt  = ctrl_reg[CTRL_CLR_CAPT] && (capt0 || capt1);
  wire clrMatch = ctrl_reg[CTRL_CLR_MATCH] && match0 && tick;
  wire clrSoft  = wrCtrl && regReq.data[CTRL_CLEAR];
  wire clrAny   = clrCapt || clrMatch || clrSoft;

  // preset source: biload alternates reg0/reg1
  wire [15:0] preset = (biLoad && biSelect_reg) ? capLoad1_reg : capLoad0_reg;
  // continuous reload at end, one shot stops
  wire reloadEnd = wrapNow && !reg0Capt && !biCapt;

  // ****************
  // register file read mux
  // ****************
  // read value is taken before any same-cycle write lands
  logic [7:0] readMux;
  always_comb begin
    unique case (regReq.addr)
      CAPLOAD0_HIGH_OFS: readMux = capLoad0_reg[15:8];
      CAPLOAD0_LOW_OFS:  readMux = capLoad0_reg[7:0];
      CAPLOAD1_HIGH_OFS: readMux = capLoad1_reg[15:8];
      CAPLOAD1_LOW_OFS:  readMux = capLoad1_reg[7:0];
      COMPARE0_HIGH_OFS: readMux = compare0_reg[15:8];
      COMPARE0_LOW_OFS:  readMux = compare0_reg[7:0];
      COMPARE1_HIGH_OFS: readMux = compare1_reg[15:8];
      COMPARE1_LOW_OFS:  readMux = compare1_reg[7:0];
      // wrap status, clear bit reads zero
      CTRL_OFS: readMux = {ctrl_reg[7:5], 1'b0, ctrl_reg[CTRL_SOFT_DIR],
                           dirUp, wrapStat_reg, runEnable};
      MODE_OFS: readMux = mode_reg;
      default:  readMux = 8'h00;   // unmapped reads as zero
    endcase
  end

  // ****************
  // read data and pin sync
  // ****************
  // read data held until next read
  always_ff @(posedge mclk) begin
    if (reset) begin
      regReadData <= 8'h00;
    end else if (regReq.read) begin
      regReadData <= readMux;
    end
  end

  // only the second stage feeds logic, the first may be metastable
  // two stages before anything reads pins
  always_ff @(posedge mclk) begin
    if (reset) begin
      pinSync1_reg <= 2'b00;
      pinSync2_reg <= 2'b00;
    end else begin
      pinSync1_reg <= {timerInputB, timerInputA};
      pinSync2_reg <= pinSync1_reg;
    end
  end

  // ****************
  // control registers
  // ****************
  // clear bit never stored
  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrl_reg <= CTRL_RESET;
      mode_reg <= MODE_RESET;
    end else begin
      if (wrCtrl) begin
        ctrl_reg <= {regReq.data[7:5], 1'b0, regReq.data[3], 3'b000};
      end
      if (wrMode) begin
        mode_reg <= regReq.data;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      compare0_reg <= COMPARE_RESET;
      compare1_reg <= COMPARE_RESET;
    end else if (wrEn) begin
      if (regReq.addr == COMPARE0_HIGH_OFS) compare0_reg[15:8] <= regReq.data;
      if (regReq.addr == COMPARE0_LOW_OFS)  compare0_reg[7:0]  <= regReq.data;
      if (regReq.addr == COMPARE1_HIGH_OFS) compare1_reg[15:8] <= regReq.data;
      if (regReq.addr == COMPARE1_LOW_OFS)  compare1_reg[7:0]  <= regReq.data;
    end
  end

  // ****************
  // capture/load registers
  // ****************
  // no reset here: content stays undefined until written or captured
  // capture wins over a same-cycle write
  always_ff @(posedge mclk) begin
    if (capt0) begin
      capLoad0_reg <= count_reg;
    end else if (wrEn && regReq.addr == CAPLOAD0_HIGH_OFS) begin
      capLoad0_reg[15:8] <= regReq.data;
    end else if (wrEn && regReq.addr == CAPLOAD0_LOW_OFS) begin
      capLoad0_reg[7:0] <= regReq.data;
    end
    if (capt1) begin
      capLoad1_reg <= count_reg;
    end else if (wrEn && regReq.addr == CAPLOAD1_HIGH_OFS) begin
      capLoad1_reg[15:8] <= regReq.data;
    end else if (wrEn && regReq.addr == CAPLOAD1_LOW_OFS) begin
      capLoad1_reg[7:0] <= regReq.data;
    end
  end

  // ****************
  // counter and prescaler
  // ****************
  // clears take priority over loads and ticks
  always_ff @(posedge mclk) begin
    if (reset) begin
      count_reg    <= COUNT_BOTTOM;
      prescale_reg <= 8'h00;
    end else if (clrAny) begin
      count_reg    <= COUNT_BOTTOM;
      prescale_reg <= prescalePreset;
    end else if (loadTrig || reloadEnd) begin
      count_reg    <= preset;
      prescale_reg <= prescalePreset;
    end else if (tick) begin
      count_reg    <= dirUp ? count_reg + 16'h0001 : count_reg - 16'h0001;
      prescale_reg <= prescalePreset;
    end else if (runEnable) begin
      prescale_reg <= prescale_reg - 8'h01;
    end
  end

  // limitation: only a load trigger with retrigger allowed, or any control write while the local enable is off, restarts it
  // one shot halts at end of count
  always_ff @(posedge mclk) begin
    if (reset) begin
      oneShotDone_reg <= 1'b0;
      biSelect_reg    <= 1'b0;
    end else begin
      if (retrig || (wrCtrl && !ctrl_reg[CTRL_LOCAL_EN])) begin
        oneShotDone_reg <= 1'b0;
      end else if (wrapNow && mode_reg[MODE_ONE_SHOT]) begin
        oneShotDone_reg <= 1'b1;
      end
      // bivalue alternates on each end or capture
      if ((biLoad && wrapNow) || (biCapt && trig.capture0)) begin
        biSelect_reg <= !biSelect_reg;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      wrapSinceCap_reg <= 1'b0;
      wrapStat_reg     <= 1'b0;
    end else if (capt0) begin
      wrapStat_reg     <= wrapSinceCap_reg || wrapNow;
      wrapSinceCap_reg <= 1'b0;
    end else if (wrapNow) begin
      wrapSinceCap_reg <= 1'b1;
    end
  end

  // ****************
  // events and pins
  // ****************
  // disabled output forced high
  // clock control bit drives parallel mode
  // compare pulses on equality while ticking
  always_ff @(posedge mclk) begin
    if (reset) begin
      timerOutputA  <= 1'b1;
      timerOutputB  <= 1'b1;
      wrapEvent     <= 1'b0;
      compare0Event <= 1'b0;
      compare1Event <= 1'b0;
      parallelMode  <= 1'b0;
      inputLevel    <= 2'b00;
    end else begin
      timerOutputA  <= mode_reg[MODE_OUT_A_EN] ? actionLevelA : 1'b1;
      timerOutputB  <= mode_reg[MODE_OUT_B_EN] ? actionLevelB : 1'b1;
      wrapEvent     <= wrapNow && !clrSoft;
      compare0Event <= match0 && tick;
      compare1Event <= match1 && tick;
      parallelMode  <= mode_reg[MODE_CLK_CTRL];
      inputLevel    <= pinSync2_reg;
    end
  end

  // ****************
  // end-of-block flags, per channel
  // ****************
  // one copy per dma channel: bit 0 capture side, bit 1 compare side
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_eob
      // software write of one with swap irqs
      wire swSet  = eobWrite && eobWriteData[ch];
      wire swClr  = eobWrite && !eobWriteData[ch];
      wire irqSet = eobEvent[ch] || (swSet && swapEnable);
      always_ff @(posedge mclk) begin
        if (reset) begin
          endOfBlockFlag[ch] <= 1'b0;
          dmaMaskClear[ch]   <= 1'b0;
          eobPend_reg[ch]    <= 1'b0;
          eobIrqServe[ch]    <= 1'b0;
        end else begin
          // set wins over a same-cycle clear
          if (eobEvent[ch] || swSet) begin
            endOfBlockFlag[ch] <= 1'b1;
          end else if (swClr) begin
            endOfBlockFlag[ch] <= 1'b0;
          end
          // second end before clear drops dma
          dmaMaskClear[ch] <= eobEvent[ch] && endOfBlockFlag[ch];
          if (irqSet) begin
            eobPend_reg[ch] <= 1'b1;
          end else if (eobIrqServe[ch]) begin
            eobPend_reg[ch] <= 1'b0;
          end
          // served below dma and wrap irq
          eobIrqServe[ch] <= eobPend_reg[ch] && !eobIrqServe[ch] &&
                             (dmaPending == 2'b00) && !wrapIrqPending;
        end
      end
    end
  endgenerate

endmodule // mft_timer_control

// ---- testbench/mft_timer_control_props.sv ----
/*
  checker for the timer control block: register reads, mode outputs, end-of-block.
  assumes one clock and a synchronous active-high reset, bound to the top module.
*/
`timescale 1ns/1ps

module mft_timer_control_props
  import mft_pkg::*;
(
  // clock and reset
  input wire logic           mclk,
  input wire logic           reset,
  // register port
  input wire mft_regreq_type regReq,
  input wire logic [7:0]     regReadData,
  // pins and mode
  input wire logic           timerOutputA,
  input wire logic           timerOutputB,
  input wire logic           parallelMode,
  // end-of-block side
  input wire logic [1:0]     eobEvent,
  input wire logic [1:0]     dmaPending,
  input wire logic           wrapIrqPending,
  input wire logic [1:0]     endOfBlockFlag,
  input wire logic [1:0]     dmaMaskClear,
  input wire logic [1:0]     eobIrqServe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  // shadows of written bytes, rebuilt from the port alone
  logic [7:0] modeShadow;
  logic [7:0] cmpHighShadow;
  wire        modeWr = regReq.write && (regReq.addr == MODE_OFS);
  wire        cmpWr  = regReq.write && (regReq.addr == COMPARE0_HIGH_OFS);

  // shadow update, reset values follow the register table
  always_ff @(posedge mclk) begin
    if (reset) begin
      modeShadow    <= MODE_RESET;
      cmpHighShadow <= COMPARE_RESET[15:8];
    end else begin
      if (modeWr) modeShadow <= regReq.data;
      if (cmpWr) cmpHighShadow <= regReq.data;
    end
  end

  // a second hit while the flag still stands
  sequence sDoubleSet;
    eobEvent[1] && endOfBlockFlag[1];
  endsequence

  chk_out_a_high: assert property (!modeShadow[MODE_OUT_A_EN] && !$past(modeShadow[MODE_OUT_A_EN]) |-> timerOutputA)
    else $error("output a not high while disabled");
  chk_out_b_high: assert property (!modeShadow[MODE_OUT_B_EN] && !$past(modeShadow[MODE_OUT_B_EN]) |-> timerOutputB)
    else $error("output b not high while disabled");
  chk_parallel_follows: assert property ((modeShadow[MODE_CLK_CTRL] == $past(modeShadow[MODE_CLK_CTRL]))
    |-> parallelMode == modeShadow[MODE_CLK_CTRL]) else $error("parallel mode differs from mode bit");
  chk_eob_sets: assert property (eobEvent != 2'b00 |=> (endOfBlockFlag & $past(eobEvent)) == $past(eobEvent))
    else $error("end of block flag not set");
  chk_mask_clear: assert property (sDoubleSet |=> dmaMaskClear[1])
    else $error("no dma mask clear on second set");
  chk_mask_cause: assert property (dmaMaskClear[1] |-> $past(eobEvent[1] && endOfBlockFlag[1]))
    else $error("dma mask clear without cause");
  chk_serve_blocked: assert property (eobIrqServe != 2'b00 |-> $past(dmaPending == 2'b00 && !wrapIrqPending))
    else $error("irq served while dma or wrap pending");
  chk_clear_reads_zero: assert property (regReq.read && regReq.addr == CTRL_OFS |=> !regReadData[CTRL_CLEAR])
    else $error("counter clear bit read as one");
  chk_cmp_readback: assert property (regReq.read && regReq.addr == COMPARE0_HIGH_OFS
    |=> regReadData == $past(cmpHighShadow)) else $error("compare high readback wrong");
endmodule // mft_timer_control_props

bind mft_timer_control mft_timer_control_props chk_u (.mclk(mclk), .reset(reset), .regReq(regReq),
  .regReadData(regReadData), .timerOutputA(timerOutputA), .timerOutputB(timerOutputB), .parallelMode(parallelMode),
  .eobEvent(eobEvent), .dmaPending(dmaPending), .wrapIrqPending(wrapIrqPending), .endOfBlockFlag(endOfBlockFlag),
  .dmaMaskClear(dmaMaskClear), .eobIrqServe(eobIrqServe));

// ---- testbench/mft_pin_partner.sv ----
/*
  behavioural model of the timer pins: drives the inputs, takes the outputs but never reads them.
  assumes the bench sets the wanted pin levels; pins move off the clock edge.
*/
`timescale 1ns/1ps

module mft_pin_partner (
  // wanted levels
  input  wire logic reqA,
  input  wire logic reqB,
  // timer pins
  input  wire logic timerOutputA,
  input  wire logic timerOutputB,
  output logic      timerInputA,
  output logic      timerInputB
);
  // pins follow the request a few ns later, unrelated to the clock
  // continuous assigns so the pins carry the starting level from 3 ns (A) and 7 ns (B) after time zero
  assign #3 timerInputA = reqA;
  assign #7 timerInputB = reqB;
endmodule // mft_pin_partner

// ---- testbench/tb_top.sv ----
/*
  self-checking bench of the timer control block.
  assumes the design package and the pin partner model are compiled first.
*/
`timescale 1ns/1ps

module tb_top;
  import mft_pkg::*;
  logic           mclk = 0, reset = 1, eobWrite = 0, swapEnable = 0, wrapIrqPending = 0;
  logic           actionLevelA = 1, actionLevelB = 1, globalCountEnable = 1, pinReqA = 1, pinReqB = 0;
  mft_regreq_type regReq = '0;
  mft_trig_type   trig = 6'h04;  // gate open, soft direction
  logic [7:0]     regReadData, rv;
  logic [1:0]     eobEvent = '0, eobWriteData = '0, dmaPending = 2'b11;
  logic [1:0]     endOfBlockFlag, dmaMaskClear, eobIrqServe, inputLevel;
  logic           timerInputA, timerInputB, timerOutputA, timerOutputB, hit;
  logic           wrapEvent, compare0Event, compare1Event, parallelMode;
  int             mismatches = 0, num_checks = 0;
  wire [4:0]      evtVec = {wrapEvent, compare1Event, eobIrqServe, compare0Event};

  always #12.5 mclk = ~mclk;

  mft_pin_partner pin_u (.reqA(pinReqA), .reqB(pinReqB), .timerOutputA(timerOutputA),
    .timerOutputB(timerOutputB), .timerInputA(timerInputA), .timerInputB(timerInputB));
  mft_timer_control dut_u (.mclk(mclk), .reset(reset), .regReq(regReq), .regReadData(regReadData),
    .globalCountEnable(globalCountEnable), .prescalePreset(8'h00), .trig(trig), .timerInputA(timerInputA),
    .timerInputB(timerInputB), .actionLevelA(actionLevelA), .actionLevelB(actionLevelB),
    .timerOutputA(timerOutputA), .timerOutputB(timerOutputB), .eobEvent(eobEvent), .eobWrite(eobWrite),
    .eobWriteData(eobWriteData), .swapEnable(swapEnable), .dmaPending(dmaPending),
    .wrapIrqPending(wrapIrqPending), .endOfBlockFlag(endOfBlockFlag), .dmaMaskClear(dmaMaskClear),
    .eobIrqServe(eobIrqServe), .wrapEvent(wrapEvent), .compare0Event(compare0Event),
    .compare1Event(compare1Event), .parallelMode(parallelMode), .inputLevel(inputLevel));

  // closing report, the only place the run ends
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // one comparison, four-state exact
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // register write: strobe for one edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk) regReq <= '{1'b1, 1'b0, a, d};
    @(posedge mclk) regReq <= '0;
  endtask

  // register read, data sampled after the taking edge
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk) regReq <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge mclk) regReq <= '0;
    #1 chk(regReadData, exp);
  endtask

  // bounded wait: 0 compare0, 1..2 irq serve, 3 compare1, 4 wrap; a hang ends the run
  task automatic waitEvt(input int sel, input int lim);
    hit = 0;
    repeat (lim) begin
      @(posedge mclk) #1;
      if (evtVec[sel] === 1'b1) begin
        hit = 1;
        break;
      end
    end
    if (!hit) begin
      mismatches++;
      $display("mismatch at %0t got %h exp %h", $time, hit, 1'b1);
      end_of_test();
    end
  endtask

  // capture0 strobe for one cycle
  task automatic capture0();
    @(posedge mclk) trig.capture0 <= 1'b1;
    @(posedge mclk) trig.capture0 <= 1'b0;
  endtask

  // reset values and unmapped read
  task automatic s_reset_values();
    for (int a = 8'hf4; a <= 8'hf9; a++) rdchk(8'(a), 8'h00);
    rdchk(8'h10, 8'h00);
  endtask

  // counting, compare match, direction and run status
  task automatic s_count();
    wr(COMPARE0_LOW_OFS, 8'h40);
    wr(CTRL_OFS, 8'h98);
    waitEvt(0, 300);
    rdchk(CTRL_OFS, 8'h8d);
    @(posedge mclk) trig.dirFixed <= 1'b1;
    rdchk(CTRL_OFS, 8'h89);
    @(posedge mclk) {trig.dirFixed, globalCountEnable} <= 2'b00;
    rdchk(CTRL_OFS, 8'h8c);
    @(posedge mclk) globalCountEnable <= 1'b1;
  endtask

  // clear on capture, then capture while stopped
  task automatic s_capture();
    wr(MODE_OFS, 8'h08);
    wr(CTRL_OFS, 8'hc8);
    repeat (20) @(posedge mclk);
    capture0();
    wr(CTRL_OFS, 8'h48);
    capture0();
    rdchk(CAPLOAD0_HIGH_OFS, 8'h00);
    @(posedge mclk) regReq <= '{1'b0, 1'b1, CAPLOAD0_LOW_OFS, 8'h00};
    @(posedge mclk) regReq <= '0;
    #1 chk(regReadData < 8'h08, 1'b1);
    wr(CTRL_OFS, 8'h10);
    capture0();
    rdchk(CAPLOAD0_LOW_OFS, 8'h00);
    rdchk(CTRL_OFS, 8'h00);
    wr(COMPARE1_HIGH_OFS, 8'hff);
    wr(COMPARE1_LOW_OFS, 8'hf0);
    wr(CTRL_OFS, 8'h80);
    waitEvt(4, 3);
    waitEvt(3, 40);
    capture0();
    rdchk(CTRL_OFS, 8'h83);
  endtask

  // output enables and clock control
  task automatic s_outputs();
    @(posedge mclk) {actionLevelB, actionLevelA} <= 2'b00;
    repeat (3) @(posedge mclk);
    #1 chk({timerOutputB, timerOutputA}, 2'b11);
    wr(MODE_OFS, 8'hcc);
    repeat (3) @(posedge mclk);
    #1 chk({timerOutputB, timerOutputA, parallelMode}, 3'b001);
    rdchk(MODE_OFS, 8'hcc);
    wr(COMPARE0_HIGH_OFS, 8'h5a);
    rdchk(COMPARE0_HIGH_OFS, 8'h5a);
    wr(MODE_OFS, 8'h08);
  endtask

  // end-of-block flags, protection and irq serving
  task automatic s_eob();
    @(posedge mclk) eobEvent <= 2'b10;
    @(posedge mclk) eobEvent <= 2'b00;
    #1 chk(endOfBlockFlag, 2'b10);
    @(posedge mclk) eobEvent <= 2'b10;
    @(posedge mclk) eobEvent <= 2'b00;
    #1 chk(dmaMaskClear, 2'b10);
    repeat (3) @(posedge mclk);
    #1 chk(eobIrqServe, 2'b00);
    @(posedge mclk) dmaPending <= 2'b00;
    waitEvt(2, 10);
    @(posedge mclk) {eobWrite, eobWriteData} <= 3'b100;
    @(posedge mclk) eobWrite <= 1'b0;
    #1 chk(endOfBlockFlag, 2'b00);
    @(posedge mclk) {swapEnable, dmaPending} <= 3'b101;
    @(posedge mclk) {eobWrite, eobWriteData} <= 3'b101;
    @(posedge mclk) eobWrite <= 1'b0;
    #1 chk(endOfBlockFlag, 2'b01);
    repeat (3) @(posedge mclk);
    #1 chk(eobIrqServe, 2'b00);
    @(posedge mclk) {wrapIrqPending, dmaPending} <= 3'b100;
    repeat (3) @(posedge mclk);
    #1 chk(eobIrqServe, 2'b00);
    @(posedge mclk) wrapIrqPending <= 1'b0;
    waitEvt(1, 10);
  endtask

  // pin levels through the synchroniser
  task automatic s_pins();
    repeat (6) @(posedge mclk);
    #1 chk(inputLevel, 2'b01);
    @(posedge mclk) {pinReqB, pinReqA} <= 2'b10;
    repeat (6) @(posedge mclk);
    #1 chk(inputLevel, 2'b10);
  endtask

  // main sequence
  initial begin
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    s_reset_values();
    s_count();
    s_capture();
    s_outputs();
    s_eob();
    s_pins();
    end_of_test();
  end
endmodule // tb_top
